/* dv/sto_relay_model.sv */
// model of the external two-channel safety relay
// assumes energise and split come from the bench
`timescale 1ns/100ps
`default_nettype none
module sto_relay_model (
  input wire logic energise,
  input wire logic split,
  output logic sto_in1,
  output logic sto_in2
);
  // two contacts with unequal switching delay; split opens only contact 2
  assign #1 sto_in1 = energise;
  assign #2 sto_in2 = energise & ~split;
endmodule : sto_relay_model
`default_nettype wire

/* dv/test_safe_torque_off_interlock.sv */
// self-checking bench for the sto interlock
// assumes sto_defs.svh and sto_pkg are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "sto_defs.svh"
module test_safe_torque_off_interlock;
  import sto_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, mains_ok, start_cmd, fault_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, sto_in1, sto_in2, torque_enable, relay1_closed, relay2_closed;
  logic drive_healthy, irq, energise, split, q_err;
  disp_t display;
  logic [7:0] fault_code;
  int n_errors = 0;
  int tests_run = 0;
  sto_interlock #(.MISMATCH_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sto_in1(sto_in1), .sto_in2(sto_in2),
    .mains_ok(mains_ok), .start_cmd(start_cmd), .fault_reset(fault_reset),
    .torque_enable(torque_enable), .relay1_closed(relay1_closed),
    .relay2_closed(relay2_closed), .drive_healthy(drive_healthy), .display(display),
    .fault_code(fault_code), .irq(irq));
  sto_relay_model u_relay (.energise(energise), .split(split), .sto_in1(sto_in1),
    .sto_in2(sto_in2));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task test_done;
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
    q = prdata;
    q_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
    chk("pslverr", 32'h0, {31'h0, q_err});
  endtask : rd
  task wait_te(input logic v, input int lim);
    int n;
    n = 0;
    while (torque_enable !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("torque_enable", {31'h0, v}, {31'h0, torque_enable});
    if (n >= lim && torque_enable !== v) test_done();
  endtask : wait_te
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    wait_te(1'b0, 2);
    rd("relay_sel", `ADDR_RELAY, 32'h0);
    rd("status", `ADDR_STATUS, 32'h0000_000C);
    rd("unmapped", 12'h01C, 32'h0);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0003);
    rd("ctrl", `ADDR_CTRL, 32'h0000_0003);
    rd("irq_clr", `ADDR_IRQ_CLR, 32'h0);
  endtask : t_reset
  task t_run;
    apb(1'b1, `ADDR_IRQ_EN, 32'h0000_000F);
    apb(1'b1, `ADDR_RELAY, 32'h0000_0D0D);
    start_cmd <= 1'b1;
    wait_te(1'b1, 8);
    chk("display", DISP_RUN, display);
    chk("relay1", 32'h1, relay1_closed);
    rd("status", `ADDR_STATUS, 32'h0000_000D);
  endtask : t_run
  task t_drop;
    energise <= 1'b0;
    wait_te(1'b0, 4);
    tick(1);
    chk("relay1", 32'h0, relay1_closed);
    chk("relay2", 32'h0, relay2_closed);
    chk("display", DISP_INHIBIT, display);
    mains_ok <= 1'b0;
    tick(1);
    chk("display_no_mains", DISP_STOP, display);
    mains_ok <= 1'b1;
    rd("status", `ADDR_STATUS, 32'h0000_0012);
    chk("irq", 32'h1, irq);
    apb(1'b1, `ADDR_IRQ_EN, 32'h0);
    chk("irq_masked", 32'h0, irq);
    start_cmd <= 1'b0;
    tick(2);
    apb(1'b1, `ADDR_IRQ_CLR, 32'h0000_000F);
    apb(1'b1, `ADDR_IRQ_EN, 32'h0000_000F);
    chk("irq_cleared", 32'h0, irq);
    start_cmd <= 1'b1;
    tick(10);
    chk("torque_enable", 32'h0, torque_enable);
    chk("display", DISP_INHIBIT, display);
    apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
    chk("start_ignored", 32'h1, q[3]);
  endtask : t_drop
  task t_fault;
    energise <= 1'b1;
    split <= 1'b1;
    tick(12);
    chk("torque_enable", 32'h0, torque_enable);
    chk("fault_code", `FAULT_STO_CODE, fault_code);
    chk("healthy", 32'h0, drive_healthy);
    chk("display", DISP_TRIP, display);
    rd("fault_reg", `ADDR_FAULT, 32'h0000_001D);
    split <= 1'b0;
    tick(6);
    chk("torque_enable", 32'h0, torque_enable);
    fault_reset <= 1'b1;
    tick(1);
    fault_reset <= 1'b0;
    wait_te(1'b1, 10);
    chk("healthy", 32'h1, drive_healthy);
    chk("fault_code", 32'h0, fault_code);
  endtask : t_fault
  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; mains_ok = 1'b1; start_cmd = 1'b0; fault_reset = 1'b0;
    energise = 1'b1; split = 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(4);
    t_reset();
    t_run();
    t_drop();
    t_fault();
    test_done();
  end
endmodule : test_safe_torque_off_interlock
`default_nettype wire

/* shared/sto_defs.svh */
// constants for the safe-torque-off interlock
// assumes a 200 MHz pclk and an apb master on the register bus
`ifndef STO_DEFS_SVH
`define STO_DEFS_SVH
`define CLK_PERIOD_NS 5
`define TORQUE_LIMIT_NS 1000
`define TORQUE_LIMIT_CYC (`TORQUE_LIMIT_NS / `CLK_PERIOD_NS)
`define STATUS_LIMIT_MS 20
`define STATUS_LIMIT_CYC (`STATUS_LIMIT_MS * 1000000 / `CLK_PERIOD_NS)
`define MISMATCH_CYC_DEF 32'd1000
`define RELAY_STO_FUNC 8'h0D
`define FAULT_STO_CODE 8'h1D
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_RELAY 12'h008
`define ADDR_IRQ_STAT 12'h00C
`define ADDR_IRQ_EN 12'h010
`define ADDR_IRQ_CLR 12'h014
`define ADDR_FAULT 12'h018
`define EV_STO_ON 0
`define EV_STO_OFF 1
`define EV_FAULT 2
`define EV_START_IGN 3
`define EV_W 4
`endif

/* shared/sto_pkg.sv */
// types for the safe-torque-off interlock
// assumes sto_defs.svh is included by users
package sto_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_RUN = 2'b01,
    ST_STO = 2'b10
  } mode_t;
  typedef enum logic [1:0] {
    DISP_STOP = 2'b00,
    DISP_RUN = 2'b01,
    DISP_INHIBIT = 2'b10,
    DISP_TRIP = 2'b11
  } disp_t;
endpackage : sto_pkg

/* verilog/sto_interlock.sv */
// safe-torque-off interlock with apb registers and interrupt
// assumes apb master on pclk; sto inputs are raw pin levels
`timescale 1ns/100ps
`default_nettype none
`include "sto_defs.svh"
module sto_interlock #(
  parameter int unsigned MISMATCH_CYC = `MISMATCH_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sto_in1,
  input wire logic sto_in2,
  input wire logic mains_ok,
  input wire logic start_cmd,
  input wire logic fault_reset,
  output logic torque_enable,
  output logic relay1_closed,
  output logic relay2_closed,
  output logic drive_healthy,
  output sto_pkg::disp_t display,
  output logic [7:0] fault_code,
  output logic irq
);
  import sto_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic ch1, ch2;
  sto_sync u_sync1 (.pclk(pclk), .presetn(presetn), .d(sto_in1), .q(ch1));
  sto_sync u_sync2 (.pclk(pclk), .presetn(presetn), .d(sto_in2), .q(ch2));

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mode_t mode;
    logic tripped;
    logic [31:0] mis_cnt;
    logic [7:0] relay1_function_select;
    logic [7:0] relay2_function_select;
    logic [1:0] start_source_select;
    logic [`EV_W-1:0] irq_stat;
    logic [`EV_W-1:0] irq_en;
    logic [31:0] rdata;
    logic [7:0] fcode;
  } state_t;
  state_t r, next_r;

  logic sto_active;
  logic wr, rd;
  logic [`EV_W-1:0] ev;
  logic mismatch;

  assign sto_active = !(ch1 && ch2);
  assign mismatch = ch1 ^ ch2;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  always_comb begin
    next_r = r;
    ev = '0;
    // ----------------------------------------
    // channel fault detection
    // ----------------------------------------
    if (mismatch) begin
      if (r.mis_cnt < MISMATCH_CYC) begin
        next_r.mis_cnt = r.mis_cnt + 32'd1;
      end
    end else begin
      next_r.mis_cnt = '0;
    end
    if (mismatch && r.mis_cnt == MISMATCH_CYC - 1 && !r.tripped) begin
      next_r.tripped = 1'b1;
      next_r.fcode = `FAULT_STO_CODE;
      ev[`EV_FAULT] = 1'b1;
    end else if (fault_reset && !mismatch) begin
      next_r.tripped = 1'b0;
      next_r.fcode = 8'h00;
    end
    // ----------------------------------------
    // mode machine
    // ----------------------------------------
    unique case (r.mode)
      ST_STANDBY: begin
        if (sto_active) begin
          next_r.mode = ST_STO;
          ev[`EV_STO_ON] = 1'b1;
        end else if (start_cmd && !r.tripped) begin
          next_r.mode = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sto_active) begin
          next_r.mode = ST_STO;
          ev[`EV_STO_ON] = 1'b1;
        end else if (!start_cmd || r.tripped) begin
          next_r.mode = ST_STANDBY;
        end
      end
      ST_STO: begin
        if (start_cmd) begin
          ev[`EV_START_IGN] = 1'b1;
        end
        if (!sto_active && !r.tripped && !(fault_reset && mismatch)) begin
          next_r.mode = ST_STANDBY;
          ev[`EV_STO_OFF] = 1'b1;
        end
      end
      default: begin
        next_r.mode = ST_STO;
      end
    endcase
    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    if (wr) begin
      unique case (paddr)
        `ADDR_CTRL: next_r.start_source_select = pwdata[1:0];
        `ADDR_RELAY: begin
          next_r.relay1_function_select = pwdata[7:0];
          next_r.relay2_function_select = pwdata[15:8];
        end
        `ADDR_IRQ_EN: next_r.irq_en = pwdata[`EV_W-1:0];
        `ADDR_IRQ_CLR: next_r.irq_stat = r.irq_stat & ~pwdata[`EV_W-1:0];
        default: ;
      endcase
    end
    next_r.irq_stat = next_r.irq_stat | ev;
    next_r.rdata = '0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `ADDR_CTRL: next_r.rdata = {30'h0, r.start_source_select};
        `ADDR_STATUS: next_r.rdata = {26'h0, r.tripped, sto_active, ch2, ch1, r.mode};
        `ADDR_RELAY: next_r.rdata = {16'h0, r.relay2_function_select,
                                     r.relay1_function_select};
        `ADDR_IRQ_STAT: next_r.rdata = {28'h0, r.irq_stat};
        `ADDR_IRQ_EN: next_r.rdata = {28'h0, r.irq_en};
        `ADDR_FAULT: next_r.rdata = {24'h0, r.fcode};
        default: next_r.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{mode: ST_STO, tripped: 1'b0, mis_cnt: 32'h0,
             relay1_function_select: 8'h00, relay2_function_select: 8'h00,
             start_source_select: 2'h0, irq_stat: '0, irq_en: '0,
             rdata: 32'h0, fcode: 8'h00};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = rd ? r.rdata : 32'h0;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // combinational gate keeps the torque block within a few cycles
  assign torque_enable = (r.mode == ST_RUN) && !sto_active && !r.tripped;
  assign relay1_closed = !(sto_active && r.relay1_function_select == `RELAY_STO_FUNC);
  assign relay2_closed = !(sto_active && r.relay2_function_select == `RELAY_STO_FUNC);
  assign drive_healthy = !r.tripped;
  assign fault_code = r.fcode;
  assign irq = |(r.irq_stat & r.irq_en);

  always_comb begin
    if (r.tripped) begin
      display = DISP_TRIP;
    end else if (sto_active && mains_ok) begin
      display = DISP_INHIBIT;
    end else if (r.mode == ST_RUN) begin
      display = DISP_RUN;
    end else begin
      display = DISP_STOP;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sto_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    sto_active |-> !torque_enable ##1 (r.mode == ST_STO)) else $error("torque while sto active");
  torque_deadline_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sto_in1) |-> ##[1:3] !torque_enable) else $error("torque not blocked in time");
  chan2_deadline_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sto_in2) |-> ##[1:3] !torque_enable)
    else $error("torque not blocked after channel 2 drop");
  start_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.mode == ST_STO && sto_active && start_cmd) |=> r.mode == ST_STO)
    else $error("start accepted in sto");
  leave_needs_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(r.tripped) |-> $past(fault_reset) && !$past(mismatch))
    else $error("trip cleared without reset");
  exit_cond_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.mode == ST_STO && (sto_active || r.tripped)) |=> r.mode == ST_STO)
    else $error("sto left with cause present");
  relay1_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sto_active && r.relay1_function_select == `RELAY_STO_FUNC) |-> !relay1_closed)
    else $error("relay 1 closed in sto");
  relay2_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sto_active && r.relay2_function_select == `RELAY_STO_FUNC) |-> !relay2_closed)
    else $error("relay 2 closed in sto");
  fault_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.tripped) |-> fault_code == `FAULT_STO_CODE && !drive_healthy)
    else $error("trip without code 29");
  inhibit_disp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sto_active && mains_ok && !r.tripped) |-> display == DISP_INHIBIT)
    else $error("inhibit not shown");
  trip_disp_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.tripped |-> display == DISP_TRIP) else $error("trip not shown");
  run_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.mode == ST_STANDBY && !sto_active && start_cmd && !r.tripped) |=> r.mode == ST_RUN)
    else $error("start not taken");
  run_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.mode == ST_RUN && !sto_active && !start_cmd) |=> r.mode == ST_STANDBY)
    else $error("run kept without start");
  display_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.mode == ST_RUN && !sto_active && !r.tripped) |-> display == DISP_RUN)
    else $error("run not shown");
  wr_no_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sto_active && wr) |=> r.mode == ST_STO)
    else $error("register write left sto");
  start_sto_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.mode == ST_STO && start_cmd) |-> !torque_enable)
    else $error("start gave torque in sto");
  mode_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.mode inside {ST_STANDBY, ST_RUN, ST_STO})
    else $error("illegal mode code");

  // ----------------------------------------
  // input and fault assertions
  // ----------------------------------------
  sync_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sto_in1 && sto_in2) [*3] |-> !sto_active)
    else $error("energised inputs not seen");
  sync_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!sto_in1) [*3] |-> sto_active)
    else $error("dropped input not seen");
  trip_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mismatch && r.mis_cnt == MISMATCH_CYC - 1) |=> r.tripped)
    else $error("channel fault not tripped");
  trip_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.tripped && fault_reset && !mismatch) |=> !r.tripped && fault_code == 8'h00)
    else $error("fault reset ignored");
  fault_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    !r.tripped |-> fault_code == 8'h00)
    else $error("fault code without trip");

  // ----------------------------------------
  // output and event status assertions
  // ----------------------------------------
  relay_closed_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sto_active |-> relay1_closed && relay2_closed)
    else $error("relay open outside sto");
  sto_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.mode != ST_STO && sto_active) |=> r.irq_stat[`EV_STO_ON])
    else $error("sto status not raised");
  ev_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev != '0) |=> (r.irq_stat & $past(ev)) == $past(ev))
    else $error("event lost");

  // ----------------------------------------
  // register assertions
  // ----------------------------------------
  stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `ADDR_IRQ_CLR && ev == '0) |=> (r.irq_stat & $past(pwdata[`EV_W-1:0])) == '0)
    else $error("status not cleared");
  prdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside access");
  pready_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable) |-> pready && !pslverr)
    else $error("access not answered");
  write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `ADDR_IRQ_EN) |=> r.irq_en == $past(pwdata[`EV_W-1:0]))
    else $error("enable write lost");
  relay_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `ADDR_RELAY) |=> r.relay1_function_select == $past(pwdata[7:0])
    && r.relay2_function_select == $past(pwdata[15:8]))
    else $error("relay select write lost");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_sto_cov: cover property (@(posedge pclk) disable iff (!presetn)
    r.mode == ST_RUN ##1 r.mode == ST_STO);
  c_trip_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(r.tripped));
  c_ignore_cov: cover property (@(posedge pclk) disable iff (!presetn) ev[`EV_START_IGN]);
  c_exit_cov: cover property (@(posedge pclk) disable iff (!presetn)
    r.mode == ST_STO ##1 r.mode == ST_STANDBY);
  c_mains_cov: cover property (@(posedge pclk) disable iff (!presetn)
    sto_active && !mains_ok && !r.tripped && display == DISP_STOP);
endmodule : sto_interlock
`default_nettype wire

/* verilog/sto_sync.sv */
// two-flop synchroniser for one sto input channel
// assumes an asynchronous level input
`timescale 1ns/100ps
`default_nettype none
module sto_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_t;
  sync_t r, next_r;
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign q = r.s2;
endmodule : sto_sync
`default_nettype wire
